//--- core/sar_adc_pkg.sv
// Constants for the converter control and serial readout block.
// Assumes a 200 MHz system clock and a host-driven shift clock.
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int CONVERSION_TIME_NS = 225;
  localparam int CONVERSION_CYCLES =
    (CONVERSION_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int ACQUISITION_TIME_NS = 175;
  localparam int ACQUISITION_CYCLES =
    (ACQUISITION_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int QUIET_TIME_NS = 15;
  localparam int QUIET_CYCLES = (QUIET_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int PULSE_MIN_NS = 10;
  localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int WAKE_NAP_NS = 50;
  localparam int WAKE_NAP_CYCLES = (WAKE_NAP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int WAKE_SLEEP_US_X10 = 11;
  localparam int WAKE_SLEEP_CYCLES =
    (WAKE_SLEEP_US_X10 * 100000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Result and counters
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 14;
  localparam int MSB_INDEX = RESULT_BITS - 1;
  localparam int EDGE_COUNT_W = 8;
  localparam int TIMER_W = 8;
  localparam int PULSE_COUNT_W = 3;
  localparam logic [TIMER_W-1:0] CONVERT_LAST = TIMER_W'(CONVERSION_CYCLES - 2);
  localparam logic [TIMER_W-1:0] DECIDE_LAST = TIMER_W'(RESULT_BITS - 1);
  localparam logic [EDGE_COUNT_W-1:0] READOUT_EDGES = EDGE_COUNT_W'(RESULT_BITS);
  localparam logic [PULSE_COUNT_W-1:0] NAP_PULSES = 3'h2;
  localparam logic [PULSE_COUNT_W-1:0] SLEEP_PULSES = 3'h4;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // Conversion sequencer states (Gray along track, convert, nap)
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_TRACK = 2'h0,
    ST_CONVERT = 2'h1,
    ST_AUTO_NAP = 2'h3
  } convert_strobe_state_t;

endpackage

//--- core/sar_adc_serial_readout.sv
// Conversion control and serial result readout of a 14-bit SAR converter.
// Assumes convert_strobe is an asynchronous pin, shift_clock is the
// host's link clock and held_level is the digitised analog input level.
`timescale 1ns/1ps

// Operation
// - A rising convert strobe starts a new conversion.
// - Conversion is internally timed; host holds strobe high 225 ns minimum.
// - After a conversion the device drops into nap by itself.
// - Serial output stays high impedance while the strobe is high.
// - Falling strobe enables the output and presents the MSB at once.
// - While the strobe is low the track-and-hold keeps sampling.
// - Each shift clock falling edge moves the output to the next bit.
// - Bits go out from most significant down to least significant.
// - Exactly 14 result bits per stream, zeros after that.
// - The bits read belong to the last conversion that ran to completion.
// - Two strobe pulses with shift clock static enter nap mode.
// - Four strobe pulses with shift clock static enter sleep mode.
// - One shift clock pulse wakes the device from strobe-pulse nap or sleep; the nap after a conversion ends only at the falling strobe.
module sar_adc_serial_readout
  import sar_adc_pkg::*;
(
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host link
  input wire logic convert_strobe,
  input wire logic shift_clock,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  // Analog front end
  input wire logic [RESULT_BITS-1:0] held_level,
  output logic track_mode,
  // Power and status
  output logic conversion_busy,
  output logic nap_mode,
  output logic sleep_mode
);

  // ----------------------------------------------------------------
  // Link domain: falling edge counter, Gray coded
  // ----------------------------------------------------------------
  logic [EDGE_COUNT_W-1:0] edge_count_bin;
  logic [EDGE_COUNT_W-1:0] edge_count_gray;

  always_ff @(negedge shift_clock or posedge rst)
  begin
    if (rst)
    begin
      edge_count_bin <= '0;
      edge_count_gray <= '0;
    end
    else
    begin
      edge_count_bin <= edge_count_bin + 1'b1;
      edge_count_gray <= (edge_count_bin + 1'b1) ^ ((edge_count_bin + 1'b1) >> 1);
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the system clock
  // ----------------------------------------------------------------
  logic strobe_sync;
  logic [EDGE_COUNT_W-1:0] edge_gray_sync;

  sync_stage #(
    .WIDTH(1)
  ) u_strobe_sync (
    .clock(clock),
    .rst(rst),
    .async_in(convert_strobe),
    .sync_out(strobe_sync)
  );

  sync_stage #(
    .WIDTH(EDGE_COUNT_W)
  ) u_edge_sync (
    .clock(clock),
    .rst(rst),
    .async_in(edge_count_gray),
    .sync_out(edge_gray_sync)
  );

  function automatic logic [EDGE_COUNT_W-1:0] gray_to_bin(input logic [EDGE_COUNT_W-1:0] g);
    logic [EDGE_COUNT_W-1:0] b;
    b = '0;
    b[EDGE_COUNT_W-1] = g[EDGE_COUNT_W-1];
    for (int i = EDGE_COUNT_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Edge detection on the synchronised strobe
  // ----------------------------------------------------------------
  logic strobe_prev;
  logic strobe_rise;
  logic strobe_fall;
  logic [EDGE_COUNT_W-1:0] edge_now;
  logic [EDGE_COUNT_W-1:0] edge_prev;
  logic shift_activity;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      strobe_prev <= 1'b0;
      edge_prev <= '0;
    end
    else
    begin
      strobe_prev <= strobe_sync;
      edge_prev <= edge_now;
    end
  end

  assign edge_now = gray_to_bin(edge_gray_sync);
  assign strobe_rise = strobe_sync & ~strobe_prev;
  assign strobe_fall = ~strobe_sync & strobe_prev;
  assign shift_activity = (edge_now != edge_prev);

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  convert_strobe_state_t state;
  logic [TIMER_W-1:0] timer;
  logic [RESULT_BITS-1:0] sample_hold;
  logic [RESULT_BITS-1:0] sar_code;
  logic [RESULT_BITS-1:0] result;
  logic [RESULT_BITS-1:0] trial;
  logic [RESULT_BITS-1:0] trial_bit;

  assign trial_bit = RESULT_BITS'(1) << (MSB_INDEX - int'(timer));
  assign trial = sar_code | trial_bit;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= ST_TRACK;
    else
    begin
      unique case (state)
        ST_TRACK:
          if (strobe_rise)
            state <= ST_CONVERT;
        ST_CONVERT:
          if (strobe_fall)
            state <= ST_TRACK;
          else if (timer == CONVERT_LAST)
            state <= ST_AUTO_NAP;
        ST_AUTO_NAP:
          if (strobe_fall)
            state <= ST_TRACK;
        default:
          state <= ST_TRACK;
      endcase
    end
  end

  // Internal conversion timer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      timer <= '0;
    else if (state != ST_CONVERT)
      timer <= '0;
    else
      timer <= timer + 1'b1;
  end

  // Hold the input at the start, then decide one bit per cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sample_hold <= RESULT_RESET;
      sar_code <= RESULT_RESET;
    end
    else if (state == ST_TRACK && strobe_rise)
    begin
      sample_hold <= held_level;
      sar_code <= RESULT_RESET;
    end
    else if (state == ST_CONVERT && timer <= DECIDE_LAST && trial <= sample_hold)
      sar_code <= trial;
  end

  // Result stands until the next conversion completes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      result <= RESULT_RESET;
    else if (state == ST_CONVERT && timer == CONVERT_LAST && !strobe_fall)
      result <= sar_code;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic [EDGE_COUNT_W-1:0] frame_base;
  logic [EDGE_COUNT_W-1:0] bit_index;
  logic frame_over;

  assign bit_index = edge_now - frame_base;

  // Frame start mark; end flag is sticky so a counter wrap never restarts the stream
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      frame_base <= '0;
      frame_over <= 1'b0;
    end
    else if (strobe_fall)
    begin
      frame_base <= edge_now;
      frame_over <= 1'b0;
    end
    else if (!strobe_sync && bit_index >= READOUT_EDGES)
      frame_over <= 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      serial_result_out <= 1'b0;
    else if (strobe_sync)
      serial_result_out <= 1'b0;
    else if (strobe_fall)
      serial_result_out <= result[MSB_INDEX];
    else if (frame_over || bit_index >= READOUT_EDGES)
      serial_result_out <= 1'b0;
    else
      serial_result_out <= result[MSB_INDEX - int'(bit_index)];
  end

  // Output enable and track follow the synchronised strobe; busy follows the sequencer state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      serial_result_oe_n <= 1'b1;
      track_mode <= 1'b1;
      conversion_busy <= 1'b0;
    end
    else
    begin
      serial_result_oe_n <= strobe_sync;
      track_mode <= ~strobe_sync;
      conversion_busy <= (state == ST_CONVERT);
    end
  end

  // ----------------------------------------------------------------
  // Nap and sleep by strobe pulses, wake by shift clock
  // ----------------------------------------------------------------
  logic [PULSE_COUNT_W-1:0] pulse_count;
  logic [EDGE_COUNT_W-1:0] pulse_mark;
  logic nap_request;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pulse_count <= '0;
      pulse_mark <= '0;
    end
    else if (shift_activity)
    begin
      pulse_count <= '0;
      pulse_mark <= edge_now;
    end
    else if (strobe_fall)
    begin
      pulse_mark <= edge_now;
      if (pulse_mark != edge_now)
      begin
        pulse_count <= 3'h1;
      end
      else if (pulse_count < SLEEP_PULSES)
      begin
        pulse_count <= pulse_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      nap_request <= 1'b0;
      sleep_mode <= 1'b0;
    end
    else if (shift_activity)
    begin
      nap_request <= 1'b0;
      sleep_mode <= 1'b0;
    end
    else
    begin
      if (pulse_count == NAP_PULSES)
        nap_request <= 1'b1;
      if (pulse_count == SLEEP_PULSES)
        sleep_mode <= 1'b1;
    end
  end

  // Reference stays up in nap; sleep overrides it from the edge sleep is decided
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      nap_mode <= 1'b0;
    else
      nap_mode <= (nap_request || state == ST_AUTO_NAP) && !sleep_mode
        && pulse_count != SLEEP_PULSES;
  end

endmodule

//--- core/sync_stage.sv
// Two-flop synchroniser for a level or a Gray-coded word.
// Assumes each bus bit changes alone (Gray) or is a slow level.
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      first_stage <= '0;
      sync_out <= '0;
    end
    else
    begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule

//--- testbench/sar_adc_chk.sv
// Port checker for the converter readout block.
// Assumes it is bound to sar_adc_serial_readout, one clock domain.
`timescale 1ns/1ps
module sar_adc_chk
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic convert_strobe,
  input wire logic shift_clock,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n,
  input wire logic track_mode,
  input wire logic conversion_busy,
  input wire logic nap_mode,
  input wire logic sleep_mode
);
  logic [7:0] busy_cnt;

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----
  // Conversion length counter
  // ----
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      busy_cnt <= 8'h00;
    else if (conversion_busy)
      busy_cnt <= busy_cnt + 8'h01;
    else
      busy_cnt <= 8'h00;
  end

  // ----
  // Properties
  // ----
  a_busy_start: assert property ($rose(convert_strobe) |-> ##[2:5] conversion_busy)
    else $error("busy late after strobe rise");
  a_convert_strobe_min: assert property ($fell(conversion_busy) && convert_strobe |-> busy_cnt >= 8'h28)
    else $error("conversion ended too early");
  a_convert_strobe_bounded: assert property (conversion_busy |-> busy_cnt < 8'h32)
    else $error("conversion ran too long");
  a_nap_after: assert property ($fell(conversion_busy) && convert_strobe |-> ##[0:2] nap_mode)
    else $error("no nap after conversion");
  a_oe_off_high: assert property (convert_strobe [*5] |-> serial_result_oe_n)
    else $error("output enabled while strobe high");
  a_out_quiet: assert property (serial_result_oe_n |-> !serial_result_out)
    else $error("output driven while disabled");
  a_oe_on_low: assert property ($fell(convert_strobe) |-> ##[1:5] !serial_result_oe_n)
    else $error("output not enabled after strobe fall");
  a_track_low: assert property (!convert_strobe [*5] |-> track_mode)
    else $error("not sampling while strobe low");
  a_hold_high: assert property (convert_strobe [*5] |-> !track_mode)
    else $error("sampling while strobe high");
  a_mode_excl: assert property (!(nap_mode && sleep_mode))
    else $error("nap and sleep together");
  a_wake_sck: assert property ($fell(shift_clock) |-> ##[1:6] !nap_mode && !sleep_mode)
    else $error("no wake after shift clock");
endmodule

bind sar_adc_serial_readout sar_adc_chk u_sar_adc_chk (
  .clock(clock), .rst(rst), .convert_strobe(convert_strobe), .shift_clock(shift_clock),
  .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
  .track_mode(track_mode), .conversion_busy(conversion_busy),
  .nap_mode(nap_mode), .sleep_mode(sleep_mode)
);

//--- testbench/sar_adc_serial_readout_tb_top.sv
// Self-checking bench for the converter readout block.
// Assumes the host model drives the link; bench drives level and reset.
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top
  import sar_adc_pkg::*;
;
  logic clock;
  logic rst;
  logic convert_strobe;
  logic shift_clock;
  logic serial_result_out;
  logic serial_result_oe_n;
  logic [RESULT_BITS-1:0] held_level;
  logic track_mode;
  logic conversion_busy;
  logic nap_mode;
  logic sleep_mode;
  int num_errors = 0;
  int checks = 0;

  sar_adc_serial_readout u_sar_adc_serial_readout (
    .clock(clock), .rst(rst), .convert_strobe(convert_strobe), .shift_clock(shift_clock),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
    .held_level(held_level), .track_mode(track_mode), .conversion_busy(conversion_busy),
    .nap_mode(nap_mode), .sleep_mode(sleep_mode)
  );

  sar_host_model u_sar_host_model (
    .clock(clock), .convert_strobe(convert_strobe), .shift_clock(shift_clock),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n)
  );

  // ----
  // Clock and helpers
  // ----
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [RESULT_BITS-1:0] got, input logic [RESULT_BITS-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_frame(input logic [13:0] lvl, input int hi, input logic [13:0] exp);
    logic [RESULT_BITS-1:0] word;
    logic tail;
    @(posedge clock);
    #1 held_level = lvl;
    u_sar_host_model.set_strobe(1'b1);
    repeat (10) @(posedge clock);
    #1 held_level = ~lvl;
    chk(14'(serial_result_oe_n), 14'h0001);
    chk(14'(track_mode), 14'h0000);
    chk(14'(conversion_busy), 14'h0001);
    repeat (hi - 10) @(posedge clock);
    #1;
    if (hi > 45)
      chk(14'(nap_mode), 14'h0001);
    u_sar_host_model.set_strobe(1'b0);
    repeat (6) @(posedge clock);
    #1;
    chk(14'(serial_result_oe_n), 14'h0000);
    chk(14'(track_mode), 14'h0001);
    chk(14'(nap_mode), 14'h0000);
    u_sar_host_model.read(word, tail);
    chk(word, exp);
    chk(14'(tail), 14'h0000);
  endtask

  task automatic t_power();
    u_sar_host_model.pulses(2);
    repeat (4) @(posedge clock);
    #1;
    chk(14'(nap_mode), 14'h0001);
    chk(14'(sleep_mode), 14'h0000);
    u_sar_host_model.wake();
    chk(14'(nap_mode), 14'h0000);
    u_sar_host_model.pulses(4);
    repeat (4) @(posedge clock);
    #1;
    chk(14'(sleep_mode), 14'h0001);
    chk(14'(nap_mode), 14'h0000);
    u_sar_host_model.wake(); // No conversion follows a sleep wake
    chk(14'(sleep_mode), 14'h0000);
  endtask

  // ----
  // Main sequence and watchdog
  // ----
  initial
  begin
    rst = 1'b1;
    held_level = 14'h0000;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    t_frame(14'h2A5C, 50, 14'h2A5C);
    t_frame(14'h3FFF, 50, 14'h3FFF);
    t_frame(14'h1555, 20, 14'h3FFF);
    t_frame(14'h0000, 50, 14'h0000);
    t_power();
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
endmodule

//--- testbench/sar_host_model.sv
// Host model: drives strobe and shift clock, reads the serial result.
// Assumes strobe edges paced by the system clock; shift clock runs 80 ns.
`timescale 1ns/1ps
module sar_host_model
  import sar_adc_pkg::*;
(
  // Pacing clock
  input wire logic clock,
  // Link
  output logic convert_strobe,
  output logic shift_clock,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n
);
  initial
  begin
    convert_strobe = 1'b0;
    shift_clock = 1'b0; // Static outside frames and wake pulses
  end

  task automatic set_strobe(input logic v);
    @(posedge clock);
    #1 convert_strobe = v;
  endtask

  task automatic sck_pulse();
    #40 shift_clock = 1'b1;
    #40 shift_clock = 1'b0;
  endtask

  // Whole readout stays inside the long low phase
  task automatic read(output logic [RESULT_BITS-1:0] word, output logic tail);
    #43 word[MSB_INDEX] = serial_result_oe_n ? 1'bx : serial_result_out;
    shift_clock = 1'b1;
    // 80 ns shift clock; each bit is taken at the rise after its falling edge
    for (int i = MSB_INDEX - 1; i >= 0; i--)
    begin
      #40 shift_clock = 1'b0;
      #40 word[i] = serial_result_oe_n ? 1'bx : serial_result_out;
      shift_clock = 1'b1;
    end
    #40 shift_clock = 1'b0;
    #40 tail = serial_result_oe_n ? 1'bx : serial_result_out;
    #20; // Quiet gap before next rise
  endtask

  // Shift clock held still while pulsing
  task automatic pulses(input int n);
    repeat (n)
    begin
      set_strobe(1'b1);
      repeat (6) @(posedge clock); // Pulse well over minimum
      set_strobe(1'b0);
      repeat (6) @(posedge clock);
    end
  endtask

  task automatic wake();
    sck_pulse();
    #50;
  endtask
endmodule
